//--- etm_map.svh
// register map, field positions, reset values and tick divider taps
// of the eight-bit timer with one compare unit; included by its bare name
`ifndef ETM_MAP_SVH
`define ETM_MAP_SVH

`define ETM_OFS_CTRL     8'h00
`define ETM_OFS_COUNT    8'h04
`define ETM_OFS_COMPARE  8'h08
`define ETM_OFS_FLAGS    8'h0C
`define ETM_OFS_IRQ_EN   8'h10

`define ETM_BIT_OVF      0
`define ETM_BIT_CMP      1

`define ETM_RST_CTRL     8'h00
`define ETM_RST_COUNT    8'h00

`define ETM_TAP_DIV8     3
`define ETM_TAP_DIV64    6
`define ETM_TAP_DIV256   8
`define ETM_TAP_DIV1024  10

`endif

//--- etm_pkg.sv
// types shared by the timer: mode codes, control word, bus data phase
// assumes the map header for offsets and field positions
package etm_pkg;

    typedef enum logic [1:0]
    {
        ETM_NORMAL = 2'b00,
        ETM_PHASE  = 2'b01,
        ETM_CTC    = 2'b10,
        ETM_FAST   = 2'b11
    } etm_mode_type;

    typedef struct packed
    {
        logic         force_compare_strobe;
        logic [1:0]   compare_output_action;
        etm_mode_type waveform_mode_select;
        logic [2:0]   clock_source_select;
    } etm_ctrl_type;

    typedef struct packed
    {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } etm_dphase_type;

endpackage : etm_pkg

//--- etm_timer.sv
// eight-bit timer/counter with one compare unit behind an AHB-Lite slave
// assumes one 25 MHz clock, synchronous active-low reset, a single-word
// master, and global enable, ack and port signals from same-clock logic
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "etm_map.svh"

module etm_timer
    import etm_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        ext_tick_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic        cmp_irq_ack_i,
    input  wire logic        ovf_irq_ack_i,
    input  wire logic        port_out_i,
    input  wire logic        output_pin_direction_bit_i,
    output logic             cmp_irq_o,
    output logic             ovf_irq_o,
    output logic             pin_o,
    output logic             pin_oe_o
);

    if (CNT_W < 2 || CNT_W > 8)
    begin : g_bad_width
        $error("etm_timer: CNT_W must lie between 2 and 8");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    etm_ctrl_type     ctrl_q;
    etm_dphase_type   dp_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] ocr_q;
    logic [CNT_W-1:0] ocr_buf_q;
    logic [9:0]       pre_q;
    logic             ext_s1_q;
    logic             ext_s2_q;
    logic             ext_s3_q;
    logic             dir_down_q;
    logic             block_q;
    logic             ovf_flag_q;
    logic             cmp_flag_q;
    logic             ovf_ie_q;
    logic             cmp_ie_q;
    logic             oc_q;

    logic             tick;
    logic             addr_ok;
    logic             wr_en;
    logic             wr_ctrl;
    logic             wr_count;
    logic             wr_cmp;
    logic             wr_flags;
    logic             wr_ie;
    logic [CNT_W-1:0] wdata;
    etm_ctrl_type     ctrl_w;
    etm_mode_type     mode;
    logic             pwm;
    logic             match_ok;
    logic             pc_up;
    logic             ovf_set;
    logic             force_hit;
    logic [31:0]      rd_data;

    assign mode = ctrl_q.waveform_mode_select;
    assign pwm  = (mode == ETM_PHASE) || (mode == ETM_FAST);

    // ---------------- bus slave ----------------
    assign addr_ok  = hsel_i && htrans_i[1] && hready_i;
    assign wr_en    = dp_q.valid && dp_q.write;
    assign wdata    = hwdata_i[CNT_W-1:0];
    assign ctrl_w   = etm_ctrl_type'(hwdata_i[7:0]);
    assign wr_ctrl  = wr_en && (dp_q.addr == `ETM_OFS_CTRL);
    assign wr_count = wr_en && (dp_q.addr == `ETM_OFS_COUNT);
    assign wr_cmp   = wr_en && (dp_q.addr == `ETM_OFS_COMPARE);
    assign wr_flags = wr_en && (dp_q.addr == `ETM_OFS_FLAGS);
    assign wr_ie    = wr_en && (dp_q.addr == `ETM_OFS_IRQ_EN);

    // upper address bits must be zero; anything else is unmapped
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            dp_q <= '0;
        end
        else if (hready_i)
        begin
            dp_q.valid <= addr_ok && (haddr_i[31:8] == 24'h000000);
            dp_q.write <= hwrite_i;
            dp_q.addr  <= haddr_i[7:0];
        end
    end

    always_comb
    begin
        rd_data = 32'h00000000;
        if (haddr_i[31:8] == 24'h000000)
        begin
            unique case (haddr_i[7:0])
                `ETM_OFS_CTRL:
                    rd_data[6:0] = ctrl_q[6:0];
                `ETM_OFS_COUNT:
                    rd_data[CNT_W-1:0] = count_q;
                `ETM_OFS_COMPARE:
                    rd_data[CNT_W-1:0] = pwm ? ocr_buf_q : ocr_q;
                `ETM_OFS_FLAGS:
                    rd_data[1:0] = {cmp_flag_q, ovf_flag_q};
                `ETM_OFS_IRQ_EN:
                    rd_data[1:0] = {cmp_ie_q, ovf_ie_q};
                default:
                    rd_data = 32'h00000000;
            endcase
        end
    end

    // read data is caught at the address phase, so no wait states
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (addr_ok && !hwrite_i)
            begin
                hrdata_o <= rd_data;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q <= etm_ctrl_type'(`ETM_RST_CTRL);
        end
        else if (wr_ctrl)
        begin
            ctrl_q                      <= ctrl_w;
            ctrl_q.force_compare_strobe <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ovf_ie_q <= 1'b0;
            cmp_ie_q <= 1'b0;
        end
        else if (wr_ie)
        begin
            ovf_ie_q <= hwdata_i[`ETM_BIT_OVF];
            cmp_ie_q <= hwdata_i[`ETM_BIT_CMP];
        end
    end

    // ---------------- tick source ----------------
    // the external input is foreign, so it passes two flops first
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            pre_q    <= 10'h000;
        end
        else
        begin
            ext_s1_q <= ext_tick_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            pre_q    <= (ctrl_q.clock_source_select == 3'h0) ? 10'h000
                                                               : pre_q + 10'h001;
        end
    end

    always_comb
    begin
        unique case (ctrl_q.clock_source_select)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &pre_q[`ETM_TAP_DIV8-1:0];
            3'h3: tick = &pre_q[`ETM_TAP_DIV64-1:0];
            3'h4: tick = &pre_q[`ETM_TAP_DIV256-1:0];
            3'h5: tick = &pre_q[`ETM_TAP_DIV1024-1:0];
            3'h6: tick = ext_s3_q && !ext_s2_q;
            3'h7: tick = ext_s2_q && !ext_s3_q;
        endcase
    end

    // ---------------- counter ----------------
    // a count write landing on a tick also counts as blocking
    assign match_ok = tick && !wr_count && !block_q
                      && (count_q == ocr_q);
    assign pc_up    = dir_down_q ? (count_q == '0) : (count_q != CNT_MAX);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            count_q <= CNT_W'(`ETM_RST_COUNT);
        end
        else if (wr_count)
        begin
            count_q <= wdata;
        end
        else if (tick)
        begin
            unique case (mode)
                ETM_NORMAL: count_q <= count_q + CNT_ONE;
                ETM_FAST:   count_q <= count_q + CNT_ONE;
                ETM_CTC:    count_q <= match_ok ? '0
                                                : count_q + CNT_ONE;
                ETM_PHASE:  count_q <= pc_up ? count_q + CNT_ONE
                                             : count_q - CNT_ONE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            dir_down_q <= 1'b0;
        end
        else if (mode != ETM_PHASE)
        begin
            dir_down_q <= 1'b0;
        end
        else if (tick && !wr_count)
        begin
            dir_down_q <= !pc_up;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            block_q <= 1'b0;
        end
        else if (wr_count)
        begin
            block_q <= 1'b1;
        end
        else if (tick)
        begin
            block_q <= 1'b0;
        end
    end

    // ---------------- flags and interrupts ----------------
    assign ovf_set = tick && !wr_count
                     && ((mode == ETM_PHASE) ? (dir_down_q && count_q == CNT_ONE)
                                             : (count_q == CNT_MAX));

    // hardware set wins over any clear in the same cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ovf_flag_q <= 1'b0;
            cmp_flag_q <= 1'b0;
        end
        else
        begin
            ovf_flag_q <= ovf_set || (ovf_flag_q && !ovf_irq_ack_i
                          && !(wr_flags && hwdata_i[`ETM_BIT_OVF]));
            cmp_flag_q <= match_ok || (cmp_flag_q && !cmp_irq_ack_i
                          && !(wr_flags && hwdata_i[`ETM_BIT_CMP]));
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cmp_irq_o <= 1'b0;
            ovf_irq_o <= 1'b0;
        end
        else
        begin
            cmp_irq_o <= cmp_flag_q && cmp_ie_q && global_irq_enable_i;
            ovf_irq_o <= ovf_flag_q && ovf_ie_q && global_irq_enable_i;
        end
    end

    // ---------------- compare value ----------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            ocr_q     <= '0;
            ocr_buf_q <= '0;
        end
        else
        begin
            if (wr_cmp)
            begin
                ocr_buf_q <= wdata;
            end
            if (!pwm)
            begin
                if (wr_cmp)
                begin
                    ocr_q <= wdata;
                end
            end
            else if (tick && !wr_count && count_q == CNT_MAX)
            begin
                ocr_q <= ocr_buf_q;
            end
        end
    end

    // ---------------- compare output ----------------
    assign force_hit = wr_ctrl && ctrl_w.force_compare_strobe
                       && ctrl_w.waveform_mode_select != ETM_PHASE
                       && ctrl_w.waveform_mode_select != ETM_FAST;

    function automatic logic non_pwm_action(input logic [1:0] act,
                                            input logic       cur);
        unique case (act)
            2'h0: non_pwm_action = cur;
            2'h1: non_pwm_action = !cur;
            2'h2: non_pwm_action = 1'b0;
            2'h3: non_pwm_action = 1'b1;
        endcase
    endfunction : non_pwm_action

    // action bits are read live, never buffered with the compare value;
    // mode changes leave the register alone
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            oc_q <= 1'b0;
        end
        else if (force_hit)
        begin
            oc_q <= non_pwm_action(ctrl_w.compare_output_action, oc_q);
        end
        else if (tick && !wr_count && ctrl_q.compare_output_action[1])
        begin
            unique case (mode)
                ETM_NORMAL, ETM_CTC:
                    if (match_ok)
                        oc_q <= non_pwm_action(ctrl_q.compare_output_action,
                                               oc_q);
                ETM_FAST:
                    if (count_q == CNT_MAX)
                        oc_q <= !ctrl_q.compare_output_action[0];
                    else if (match_ok)
                        oc_q <= ctrl_q.compare_output_action[0];
                ETM_PHASE:
                    if (match_ok)
                        oc_q <= dir_down_q ^ ctrl_q.compare_output_action[0];
            endcase
        end
        else if (tick && match_ok && !pwm)
        begin
            oc_q <= non_pwm_action(ctrl_q.compare_output_action, oc_q);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end
        else
        begin
            pin_o    <= (ctrl_q.compare_output_action != 2'h0) ? oc_q
                                                              : port_out_i;
            pin_oe_o <= output_pin_direction_bit_i;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // count writes still waiting for the tick that they block
    logic cw_pend_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cw_pend_q <= 1'b0;
        end
        else if (wr_count || tick)
        begin
            cw_pend_q <= wr_count;
        end
    end

    a_stop_no_tick: assert property (
        ctrl_q.clock_source_select == 3'h0 |-> !tick)
        else $error("tick seen while clock source is stopped");

    a_count_write_wins: assert property (
        wr_count |=> count_q == $past(wdata))
        else $error("count write did not take priority");

    a_normal_wrap_ovf: assert property (
        tick && !wr_count && mode == ETM_NORMAL && count_q == CNT_MAX
        |=> count_q == '0 && ovf_flag_q)
        else $error("normal mode wrap or overflow flag wrong");

    a_match_sets_flag: assert property (
        match_ok |=> cmp_flag_q ##1 1'b1)
        else $error("compare match did not set flag");

    a_write_blocks_match: assert property (
        (wr_count || cw_pend_q) && !cmp_flag_q |=> !cmp_flag_q)
        else $error("match not blocked after count write");

    a_irq_needs_all: assert property (
        cmp_irq_o |-> $past(cmp_flag_q && cmp_ie_q && global_irq_enable_i))
        else $error("compare interrupt without its conditions");

    a_ack_clears_flag: assert property (
        cmp_irq_ack_i && !match_ok |=> !cmp_flag_q)
        else $error("compare flag not cleared by service");

    a_action_zero_holds: assert property (
        ctrl_q.compare_output_action == 2'h0 && !wr_ctrl |=> $stable(oc_q))
        else $error("compare output changed with action zero");

    a_pin_override: assert property (
        ctrl_q.compare_output_action != 2'h0 && $stable(ctrl_q)
        |=> pin_o == $past(oc_q))
        else $error("pin not driven by compare output");

    a_ctc_clear: assert property (
        mode == ETM_CTC && match_ok |=> count_q == '0)
        else $error("clear on match mode did not clear counter");

    a_buffer_hold: assert property (
        pwm && !(tick && count_q == CNT_MAX) && $stable(ctrl_q)
        |=> $stable(ocr_q))
        else $error("active compare changed away from top");

    a_force_no_flag: assert property (
        force_hit && !match_ok && !cmp_flag_q |=> !cmp_flag_q)
        else $error("force strobe set the match flag");

endmodule : etm_timer

//--- etm_cpu_model.sv
// bus master model standing in for the processor core on AHB-Lite
// assumes one slave whose hreadyout is fed back as the bus hready
`timescale 1ns/1ns

module etm_cpu_model
(
    input  wire logic        ref_clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial
    begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h0;
    end

    // single word transfer, entered just after a rising edge
    // a released data bus shows the inverse so stale data never matches
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r);
        hsel_o   <= 1'b1;
        haddr_o  <= {24'h0, a};
        htrans_o <= 2'b10;
        hwrite_o <= w;
        @(posedge ref_clk_i);
        while (hready_i !== 1'b1)
            @(posedge ref_clk_i);
        hsel_o   <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= d;
        @(posedge ref_clk_i);
        while (hready_i !== 1'b1)
            @(posedge ref_clk_i);
        r = hrdata_i;
        hwdata_o <= ~d;
    endtask : xfer

endmodule : etm_cpu_model

//--- testbench.sv
// self-checking bench for the eight-bit timer: register call sequences
// assumes etm_cpu_model as the only bus master and the map header offsets
`timescale 1ns/1ns
`include "etm_map.svh"

module testbench
    import etm_pkg::*;
;
    logic        ref_clk_i;
    logic        rstn_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        ext_tick;
    logic        gie;
    logic        cmp_ack;
    logic        ovf_ack;
    logic        port_out;
    logic        dir;
    logic        cmp_irq;
    logic        ovf_irq;
    logic        pin;
    logic        pin_oe;
    int          fail_count;
    int          compares;

    etm_cpu_model etm_cpu_model_inst (.ref_clk_i(ref_clk_i),
        .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));

    etm_timer etm_timer_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .ext_tick_i(ext_tick),
        .global_irq_enable_i(gie), .cmp_irq_ack_i(cmp_ack),
        .ovf_irq_ack_i(ovf_ack), .port_out_i(port_out),
        .output_pin_direction_bit_i(dir), .cmp_irq_o(cmp_irq),
        .ovf_irq_o(ovf_irq), .pin_o(pin), .pin_oe_o(pin_oe));

    initial
        ref_clk_i = 1'b0;
    always #20 ref_clk_i = ~ref_clk_i;

    // keeps the external source moving so a stopped timer is a real test
    always @(posedge ref_clk_i)
        ext_tick <= ~ext_tick;

    task wrap_up;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        etm_cpu_model_inst.xfer(1'b1, a, d, r);
    endtask : wr

    task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        etm_cpu_model_inst.xfer(1'b0, a, 32'h0, r);
        check(name, r, e);
    endtask : rdc

    function logic [31:0] ctl(input logic f, input logic [1:0] act,
                              input logic [1:0] m, input logic [2:0] src);
        etm_ctrl_type c;
        c = '{f, act, etm_mode_type'(m), src};
        return {24'h0, c};
    endfunction : ctl

    // count is loaded while stopped so the start point is exact
    task run(input logic [1:0] m, input logic [7:0] cnt, input int n);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, m, 3'h0));
        wr(`ETM_OFS_COUNT, {24'h0, cnt});
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, m, 3'h1));
        tick(n);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, m, 3'h0));
    endtask : run

    task done(input string name);
        $display("test %s finished", name);
    endtask : done

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        wrap_up();
    end

    initial
    begin
        logic [31:0] r;
        rstn_i = 1'b0;
        gie = 1'b0;
        cmp_ack = 1'b0;
        ovf_ack = 1'b0;
        port_out = 1'b0;
        dir = 1'b0;
        ext_tick = 1'b0;
        fail_count = 0;
        compares = 0;
        tick(10);
        rstn_i <= 1'b1;
        tick(1);
        check("pin", {31'h0, pin}, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        rdc("ctrl", `ETM_OFS_CTRL, 32'h0);
        rdc("count", `ETM_OFS_COUNT, 32'h0);
        rdc("unmapped", 8'h14, 32'h0);
        done("reset");
        wr(`ETM_OFS_COUNT, 32'h05);
        tick(20);
        rdc("stopped count", `ETM_OFS_COUNT, 32'h05);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h1));
        wr(`ETM_OFS_COUNT, 32'h80);
        rdc("count write wins", `ETM_OFS_COUNT, 32'h80);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        done("count access");
        wr(`ETM_OFS_FLAGS, 32'h3);
        run(2'h0, 8'hFE, 8);
        rdc("wrap flags", `ETM_OFS_FLAGS, 32'h3);
        wr(`ETM_OFS_IRQ_EN, 32'h1);
        gie <= 1'b1;
        tick(2);
        check("ovf irq", {31'h0, ovf_irq}, 32'h1);
        ovf_ack <= 1'b1;
        tick(1);
        ovf_ack <= 1'b0;
        tick(2);
        check("ovf irq serviced", {31'h0, ovf_irq}, 32'h0);
        rdc("ovf cleared", `ETM_OFS_FLAGS, 32'h2);
        wr(`ETM_OFS_FLAGS, 32'h2);
        rdc("write one clears", `ETM_OFS_FLAGS, 32'h0);
        done("overflow");
        wr(`ETM_OFS_COMPARE, 32'h10);
        run(2'h0, 8'h08, 20);
        rdc("match flag", `ETM_OFS_FLAGS, 32'h2);
        wr(`ETM_OFS_IRQ_EN, 32'h2);
        gie <= 1'b0;
        tick(2);
        check("cmp irq masked", {31'h0, cmp_irq}, 32'h0);
        gie <= 1'b1;
        tick(2);
        check("cmp irq", {31'h0, cmp_irq}, 32'h1);
        cmp_ack <= 1'b1;
        tick(1);
        cmp_ack <= 1'b0;
        tick(2);
        check("cmp irq serviced", {31'h0, cmp_irq}, 32'h0);
        rdc("cmp cleared", `ETM_OFS_FLAGS, 32'h0);
        done("compare");
        // count equal to compare is written on purpose here
        wr(`ETM_OFS_COMPARE, 32'h20);
        run(2'h0, 8'h20, 20);
        rdc("blocked match", `ETM_OFS_FLAGS, 32'h0);
        done("blocking");
        wr(`ETM_OFS_COMPARE, 32'h05);
        run(2'h2, 8'h00, 60);
        etm_cpu_model_inst.xfer(1'b0, `ETM_OFS_COUNT, 32'h0, r);
        check("ctc bounded", {31'h0, r <= 32'h5}, 32'h1);
        rdc("ctc flags", `ETM_OFS_FLAGS, 32'h2);
        done("clear on match");
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h3, 3'h0));
        wr(`ETM_OFS_COMPARE, 32'h30);
        rdc("buffer read", `ETM_OFS_COMPARE, 32'h30);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        rdc("active kept", `ETM_OFS_COMPARE, 32'h05);
        run(2'h3, 8'hF0, 40);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        rdc("moved at top", `ETM_OFS_COMPARE, 32'h30);
        done("buffering");
        // run gives n+2 ticks: up FD,FE,FF then down; then down 02,01,00 up
        wr(`ETM_OFS_FLAGS, 32'h3);
        run(2'h1, 8'hFD, 4);
        rdc("phase top turn", `ETM_OFS_COUNT, 32'hFB);
        run(2'h1, 8'h02, 4);
        rdc("phase bottom turn", `ETM_OFS_COUNT, 32'h04);
        rdc("phase overflow", `ETM_OFS_FLAGS, 32'h1);
        done("phase correct");
        // divide by 8 ticks 3 times in 30 edges; external edge every other
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        wr(`ETM_OFS_COUNT, 32'h0);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h2));
        tick(28);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        rdc("divide by 8", `ETM_OFS_COUNT, 32'h3);
        wr(`ETM_OFS_COUNT, 32'h0);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h7));
        tick(20);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h0, 2'h0, 3'h0));
        rdc("external edges", `ETM_OFS_COUNT, 32'hB);
        done("tick sources");
        wr(`ETM_OFS_FLAGS, 32'h3);
        dir <= 1'b1;
        port_out <= 1'b1;
        tick(2);
        check("port drives pin", {31'h0, pin}, 32'h1);
        check("pin enable", {31'h0, pin_oe}, 32'h1);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h1, 2'h0, 3'h0));
        tick(2);
        check("oc untouched", {31'h0, pin}, 32'h0);
        wr(`ETM_OFS_CTRL, ctl(1'b1, 2'h3, 2'h0, 3'h0));
        tick(2);
        check("force set", {31'h0, pin}, 32'h1);
        rdc("strobe reads 0", `ETM_OFS_CTRL,
            ctl(1'b0, 2'h3, 2'h0, 3'h0));
        rdc("force no flag", `ETM_OFS_FLAGS, 32'h0);
        wr(`ETM_OFS_CTRL, ctl(1'b1, 2'h2, 2'h0, 3'h0));
        tick(2);
        check("force clear", {31'h0, pin}, 32'h0);
        wr(`ETM_OFS_CTRL, ctl(1'b1, 2'h1, 2'h0, 3'h0));
        tick(2);
        check("force toggle", {31'h0, pin}, 32'h1);
        wr(`ETM_OFS_CTRL, ctl(1'b0, 2'h1, 2'h3, 3'h0));
        tick(2);
        check("oc kept", {31'h0, pin}, 32'h1);
        wr(`ETM_OFS_CTRL, ctl(1'b1, 2'h2, 2'h3, 3'h0));
        tick(2);
        check("pwm force ignored", {31'h0, pin}, 32'h1);
        dir <= 1'b0;
        tick(2);
        check("pin input", {31'h0, pin_oe}, 32'h0);
        done("compare output");
        wrap_up();
    end

endmodule : testbench
